// ---- src/adc_scan_xfer.v ----
/*
 * Four channel scan converter, one shot, software trigger, with a repeat mode transfer engine
 * that copies each 16-bit result within the limits into one of four RAM slots and a completion interrupt.
 * Assumes a sample of each analog channel arrives as a 10-bit digital word on the same clock,
 * and a single port RAM write port that always accepts.
 */
// The address-and-strobe port is this design's own decision.
`include "adc_scan_map.vh"
`timescale 1ns/1ps
`default_nettype none

module adc_scan_xfer #(
    parameter integer CLK_DIV = `CLK_DIVIDE,
    parameter integer CONV_CLKS = `CONV_CLOCKS
) (
    input wire clk_sys,
    input wire rst,
    input wire [19:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire [9:0] analog_in_0,
    input wire [9:0] analog_in_1,
    input wire [9:0] analog_in_2,
    input wire [9:0] analog_in_3,
    output reg ram_we,
    output reg [19:0] ram_addr,
    output reg [15:0] ram_wdata,
    output reg conversion_end_irq,
    output reg irq
);

    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_CONV = 3'b010;
    localparam [2:0] ST_XFER = 3'b100;

    // ------------------------------------------------------------------------
    // Reset images and counts at register width
    // ------------------------------------------------------------------------
    // The map holds plain numbers; these give them the width of the registers they load.
    localparam [2:0] XCTL_INIT = `XCTL_RESET;
    localparam [2:0] XFER_INIT = `XFER_COUNT;

    // ------------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------------
    // True when a strobe addresses the given register.
    function reg_hit;
        input strobe;
        input [19:0] addr;
        input [19:0] target;
        begin
            reg_hit = strobe && (addr == target);
        end
    endfunction

    reg [2:0] state;
    reg [7:0] converter_mode_reg;
    reg [7:0] upper_limit;
    reg [7:0] lower_limit;
    reg activation_enable_conv;
    reg repeat_irq_enable;
    reg repeat_mode;
    reg [15:0] conversion_result;
    reg [1:0] chan;
    reg [3:0] div_cnt;
    reg conv_tick;
    reg [5:0] conv_cnt;
    reg [1:0] slot;
    reg [2:0] xfer_left;
    reg xfer_req;
    reg [1:0] irq_status;
    reg [1:0] irq_mask;
    reg [9:0] next_sample;
    reg next_in_limits;
    reg next_complete;

    wire wr_mode = reg_hit(reg_wr, reg_addr, `ADDR_CONVERTER_MODE);
    wire wr_upper = reg_hit(reg_wr, reg_addr, `ADDR_UPPER_LIMIT);
    wire wr_lower = reg_hit(reg_wr, reg_addr, `ADDR_LOWER_LIMIT);
    wire wr_xctl = reg_hit(reg_wr, reg_addr, `ADDR_XFER_CTRL);
    wire wr_mask = reg_hit(reg_wr, reg_addr, `ADDR_IRQ_MASK);
    wire wr_status = reg_hit(reg_wr, reg_addr, `ADDR_IRQ_STATUS);
    wire start = wr_mode && reg_wdata[`MODE_RUN_BIT];
    wire conv_done = (state == ST_CONV) && conv_tick && (conv_cnt == CONV_CLKS[5:0] - 6'd1);
    wire [1:0] irq_clear = wr_status ? reg_wdata[1:0] : 2'b00;
    // The count reloads when the fourth request is taken, so the fourth write
    // to RAM is the one that finds the count back at its full value.
    wire last_xfer = ram_we && (xfer_left == XFER_INIT);

    always @* begin
        case (chan)
            2'd0: next_sample = analog_in_0;
            2'd1: next_sample = analog_in_1;
            2'd2: next_sample = analog_in_2;
            default: next_sample = analog_in_3;
        endcase
        // Limits compare against the upper eight bits of the result.
        next_in_limits = (next_sample[9:2] >= lower_limit) && (next_sample[9:2] <= upper_limit);
        // Completion in repeat mode needs the repeat interrupt enable; normal mode ignores it.
        next_complete = last_xfer && (repeat_irq_enable || !repeat_mode);
    end

    // ------------------------------------------------------------------------
    // Conversion clock divider
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst || state != ST_CONV) begin
            div_cnt <= 4'd0;
            conv_tick <= 1'b0;
        end else if (div_cnt == CLK_DIV[3:0] - 4'd1) begin
            div_cnt <= 4'd0;
            conv_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 4'd1;
            conv_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Scan sequencer and transfer engine
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            state <= ST_IDLE;
            chan <= 2'd0;
            conv_cnt <= 6'd0;
            conversion_result <= 16'h0000;
            conversion_end_irq <= 1'b0;
            xfer_req <= 1'b0;
            ram_we <= 1'b0;
            ram_addr <= `ADDR_SLOT_BASE;
            ram_wdata <= 16'h0000;
            slot <= 2'd0;
            xfer_left <= XFER_INIT;
            converter_mode_reg <= `MODE_RESET;
        end else begin
            conversion_end_irq <= 1'b0;
            ram_we <= 1'b0;
            xfer_req <= 1'b0;
            if (wr_mode) begin
                converter_mode_reg <= reg_wdata[7:0];
            end
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_CONV;
                        chan <= 2'd0;
                        conv_cnt <= 6'd0;
                    end
                end
                ST_CONV: begin
                    if (wr_mode && !reg_wdata[`MODE_RUN_BIT]) begin
                        state <= ST_IDLE;
                    end else if (conv_done) begin
                        conversion_result <= {next_sample, 6'b000000};
                        conversion_end_irq <= next_in_limits;
                        xfer_req <= next_in_limits && activation_enable_conv;
                        conv_cnt <= 6'd0;
                        state <= ST_XFER;
                    end else if (conv_tick) begin
                        conv_cnt <= conv_cnt + 6'd1;
                    end
                end
                ST_XFER: begin
                    // The next conversion waits until the copy is written.
                    if (!xfer_req) begin
                        if (chan == 2'd3) begin
                            state <= ST_IDLE;
                            converter_mode_reg[`MODE_RUN_BIT] <= 1'b0;
                        end else begin
                            chan <= chan + 2'd1;
                            state <= ST_CONV;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
            if (xfer_req) begin
                ram_we <= 1'b1;
                ram_wdata <= conversion_result;
                ram_addr <= `ADDR_SLOT_BASE + {17'd0, slot, 1'b0};
                slot <= slot + 2'd1;
                xfer_left <= (xfer_left == 3'd1) ? XFER_INIT : xfer_left - 3'd1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Control registers, activation enable and interrupts
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            upper_limit <= `UPPER_LIMIT_RESET;
            lower_limit <= `LOWER_LIMIT_RESET;
            activation_enable_conv <= XCTL_INIT[`XCTL_ACT_EN_BIT];
            repeat_irq_enable <= XCTL_INIT[`XCTL_RPT_IRQ_EN_BIT];
            repeat_mode <= XCTL_INIT[`XCTL_REPEAT_MODE_BIT];
            irq_status <= 2'b00;
            irq_mask <= 2'b00;
            irq <= 1'b0;
        end else begin
            if (wr_upper) begin
                upper_limit <= reg_wdata[7:0];
            end
            if (wr_lower) begin
                lower_limit <= reg_wdata[7:0];
            end
            if (wr_xctl) begin
                activation_enable_conv <= reg_wdata[`XCTL_ACT_EN_BIT];
                repeat_irq_enable <= reg_wdata[`XCTL_RPT_IRQ_EN_BIT];
                repeat_mode <= reg_wdata[`XCTL_REPEAT_MODE_BIT];
            end
            // The self clear follows a software write in the same cycle, so it wins.
            if (last_xfer) begin
                activation_enable_conv <= 1'b0;
            end
            if (wr_mask) begin
                irq_mask <= reg_wdata[1:0];
            end
            // Set wins over a clear in the same cycle.
            irq_status[`IRQ_CONV_END_BIT] <= conversion_end_irq |
                (irq_status[`IRQ_CONV_END_BIT] & ~irq_clear[`IRQ_CONV_END_BIT]);
            irq_status[`IRQ_XFER_DONE_BIT] <= next_complete |
                (irq_status[`IRQ_XFER_DONE_BIT] & ~irq_clear[`IRQ_XFER_DONE_BIT]);
            irq <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_CONVERSION_RESULT: reg_rdata <= conversion_result;
                `ADDR_CONVERTER_MODE: reg_rdata <= {8'h00, converter_mode_reg};
                `ADDR_UPPER_LIMIT: reg_rdata <= {8'h00, upper_limit};
                `ADDR_LOWER_LIMIT: reg_rdata <= {8'h00, lower_limit};
                `ADDR_XFER_CTRL: reg_rdata <= {13'd0, repeat_mode, repeat_irq_enable, activation_enable_conv};
                `ADDR_XFER_STATUS: reg_rdata <= {11'd0, xfer_left, slot};
                `ADDR_IRQ_STATUS: reg_rdata <= {14'd0, irq_status};
                `ADDR_IRQ_MASK: reg_rdata <= {14'd0, irq_mask};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule // adc_scan_xfer

`default_nettype wire

// ---- src/adc_scan_map.vh ----
/*
 * Register map, field positions, reset values and timing counts of the scan converter with result transfer.
 * Assumes inclusion by the one design file of the block; definitions only.
 */
`ifndef ADC_SCAN_MAP_VH
`define ADC_SCAN_MAP_VH

// ----------------------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------------------
`define ADDR_CONVERSION_RESULT 20'hfff1e
`define ADDR_CONVERTER_MODE 20'hfff30
`define ADDR_UPPER_LIMIT 20'hfff32
`define ADDR_LOWER_LIMIT 20'hfff34
`define ADDR_XFER_CTRL 20'hfff36
`define ADDR_XFER_STATUS 20'hfff38
`define ADDR_IRQ_STATUS 20'hfff3a
`define ADDR_IRQ_MASK 20'hfff3c
`define ADDR_SLOT_BASE 20'hff900

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MODE_RUN_BIT 7
`define XCTL_ACT_EN_BIT 0
`define XCTL_RPT_IRQ_EN_BIT 1
`define XCTL_REPEAT_MODE_BIT 2
`define IRQ_CONV_END_BIT 0
`define IRQ_XFER_DONE_BIT 1

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define UPPER_LIMIT_RESET 8'hff
`define LOWER_LIMIT_RESET 8'h00
`define XCTL_RESET 3'h6
`define MODE_RESET 8'h00
`define CLK_DIVIDE 8
`define CONV_CLOCKS 16
`define XFER_COUNT 4
`define RESULT_SHIFT 6

`endif

// ---- tb/adc_scan_props.sv ----
/* Port checker of adc_scan_xfer, bound onto it.
   Assumes one clock and a synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module adc_scan_props #(parameter integer CLK_DIV = 8, parameter integer CONV_CLKS = 16) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [9:0] analog_in_0,
    input wire logic [9:0] analog_in_1,
    input wire logic [9:0] analog_in_2,
    input wire logic [9:0] analog_in_3,
    input wire logic ram_we,
    input wire logic [19:0] ram_addr,
    input wire logic [15:0] ram_wdata,
    input wire logic conversion_end_irq,
    input wire logic irq
);
    // Slot follows the transfers; hist marks, for each of the last three cycles, whether a cause of an interrupt change was seen.
    logic [1:0] slot;
    logic [2:0] hist;
    wire [9:0] chv = slot[1] ? (slot[0] ? analog_in_3 : analog_in_2) : (slot[0] ? analog_in_1 : analog_in_0);
    always @(posedge clk_sys) begin
        if (rst) begin
            slot <= 2'h0;
            hist <= 3'h0;
        end else begin
            slot <= slot + {1'b0, ram_we};
            hist <= {hist[1:0], ram_we | conversion_end_irq | reg_wr};
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside slot");
    xfer_cause_a: assert property (ram_we |-> $past(conversion_end_irq))
        else $error("transfer without conversion end");
    slot_order_a: assert property (ram_we |-> ram_addr == 20'hff900 + {17'h0, slot, 1'b0})
        else $error("bad slot address");
    slot_data_a: assert property (ram_we |-> ram_wdata == {chv, 6'h00})
        else $error("bad slot data");
    xfer_single_a: assert property (ram_we |=> !ram_we)
        else $error("transfer too long");
    conv_gap_a: assert property (conversion_end_irq |=> !conversion_end_irq [*6])
        else $error("conversions too close");
    scan_stop_a: assert property (ram_we && slot == 2'h3 |=> !conversion_end_irq [*6])
        else $error("scan did not stop");
    irq_cause_a: assert property ($changed(irq) |-> hist != 3'h0)
        else $error("interrupt changed without cause");
    cover property (ram_we && slot == 2'h3);
    cover property ($rose(irq));
    cover property (conversion_end_irq ##1 ram_we);
endmodule // adc_scan_props
bind adc_scan_xfer adc_scan_props #(.CLK_DIV(CLK_DIV), .CONV_CLKS(CONV_CLKS)) i_adc_scan_props (
    .clk_sys, .rst, .reg_wr, .reg_rd, .reg_rdata, .analog_in_0, .analog_in_1, .analog_in_2,
    .analog_in_3, .ram_we, .ram_addr, .ram_wdata, .conversion_end_irq, .irq);
`default_nettype wire

// ---- tb/scan_far_model.sv ----
/* Far side: four analog channels and the RAM slots.
   Assumes the bench loads chan between scans. */
`timescale 1ns/1ps
`default_nettype none
module scan_far_model (
    input wire logic clk_sys,
    input wire logic ram_we,
    input wire logic [19:0] ram_addr,
    input wire logic [15:0] ram_wdata,
    output wire logic [9:0] analog_in_0,
    output wire logic [9:0] analog_in_1,
    output wire logic [9:0] analog_in_2,
    output wire logic [9:0] analog_in_3
);
    logic [9:0] chan [0:3] = '{10'h000, 10'h000, 10'h000, 10'h000};
    logic [15:0] mem [0:3];
    logic [15:0] writes = 16'h0000;
    assign analog_in_0 = chan[0];
    assign analog_in_1 = chan[1];
    assign analog_in_2 = chan[2];
    assign analog_in_3 = chan[3];
    // The RAM port never stalls; one word lands per strobe.
    always @(posedge clk_sys) begin
        if (ram_we) begin
            mem[ram_addr[2:1]] <= ram_wdata;
            writes <= writes + 16'h0001;
        end
    end
endmodule // scan_far_model
`default_nettype wire

// ---- tb/adc_scan_xfer_tb.sv ----
/* Self-checking bench of adc_scan_xfer with its far side model.
   Assumes shortened conversion counts. */
`include "adc_scan_map.vh"
`timescale 1ns/1ps
`default_nettype none
module adc_scan_xfer_tb;
    localparam logic [39:0] V1 = {10'h3c1, 10'h155, 10'h2aa, 10'h001};
    localparam logic [39:0] V2 = {10'h0f0, 10'h30f, 10'h000, 10'h3ff};
    localparam logic [39:0] V3 = {10'h1fc, 10'h200, 10'h3ff, 10'h2aa};
    logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [19:0] reg_addr = 20'h00000;
    logic [15:0] reg_wdata = 16'h0000, rv;
    wire [15:0] reg_rdata, ram_wdata;
    wire [9:0] analog_in_0, analog_in_1, analog_in_2, analog_in_3;
    wire [19:0] ram_addr;
    wire ram_we, conversion_end_irq, irq;
    int num_errors = 0, n_compared = 0, cycles = 0;
    initial forever #50 clk_sys = ~clk_sys;
    adc_scan_xfer #(.CLK_DIV(2), .CONV_CLKS(4)) i_adc_scan_xfer (.clk_sys, .rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .analog_in_0, .analog_in_1, .analog_in_2, .analog_in_3, .ram_we,
        .ram_addr, .ram_wdata, .conversion_end_irq, .irq);
    scan_far_model i_scan_far_model (.clk_sys, .ram_we, .ram_addr, .ram_wdata, .analog_in_0,
        .analog_in_1, .analog_in_2, .analog_in_3);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [19:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // Arms the transfer, starts a scan and polls the run bit until the scan is over.
    task automatic run_scan(input logic [39:0] v);
        for (int k = 0; k < 4; k++) i_scan_far_model.chan[k] <= v[k*10 +: 10];
        wr(`ADDR_XFER_CTRL, 16'h0007);
        wr(`ADDR_CONVERTER_MODE, 16'h0080);
        rv = 16'hffff;
        for (int k = 0; k < 40 && rv[7] !== 1'b0; k++) begin
            @(posedge clk_sys);
            reg_addr <= `ADDR_CONVERTER_MODE;
            reg_rd <= 1'b1;
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            #1 rv = reg_rdata;
        end
        chk(rv & 16'h0080, 16'h0000);
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic chk_slots(input logic [39:0] v, input int n);
        for (int k = 0; k < n; k++) chk(i_scan_far_model.mem[k], {v[k*10 +: 10], 6'h00});
    endtask
    task automatic t_regs;
        rd(`ADDR_UPPER_LIMIT, 16'h00ff);
        rd(`ADDR_LOWER_LIMIT, 16'h0000);
        rd(`ADDR_XFER_CTRL, 16'h0006);
        rd(`ADDR_IRQ_MASK, 16'h0000);
        rd(`ADDR_IRQ_STATUS, 16'h0000);
        rd(20'hfff40, 16'h0000);
    endtask
    task automatic t_scan_irq;
        wr(`ADDR_IRQ_MASK, 16'h0003);
        run_scan(V1);
        chk_slots(V1, 4);
        wr(`ADDR_CONVERSION_RESULT, 16'h1234);
        rd(`ADDR_CONVERSION_RESULT, {V1[39:30], 6'h00});
        rd(`ADDR_XFER_CTRL, 16'h0006);
        rd(`ADDR_IRQ_STATUS, 16'h0003);
        chk({15'h0, irq}, 16'h0001);
        wr(`ADDR_IRQ_STATUS, 16'h0003);
        repeat (2) @(posedge clk_sys);
        #1 chk({15'h0, irq}, 16'h0000);
    endtask
    task automatic t_masked_restart;
        wr(`ADDR_IRQ_MASK, 16'h0000);
        run_scan(V2);
        chk_slots(V2, 4);
        rd(`ADDR_IRQ_STATUS, 16'h0003);
        chk({15'h0, irq}, 16'h0000);
        wr(`ADDR_IRQ_MASK, 16'h0002);
        repeat (2) @(posedge clk_sys);
        #1 chk({15'h0, irq}, 16'h0001);
        wr(`ADDR_IRQ_STATUS, 16'h0003);
    endtask
    // The last channel sits one step under the lower limit, the third one on it.
    task automatic t_limit;
        wr(`ADDR_LOWER_LIMIT, 16'h0080);
        run_scan(V3);
        chk_slots(V3, 3);
        chk(i_scan_far_model.writes, 16'h000b);
        rd(`ADDR_IRQ_STATUS, 16'h0001);
    endtask
    task automatic print_verdict;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_scan_irq();
        t_masked_restart();
        t_limit();
        print_verdict();
    end
endmodule // adc_scan_xfer_tb
`default_nettype wire
